// File: rtl/adc_i2c_defs.svh
`ifndef ADC_I2C_DEFS_SVH
`define ADC_I2C_DEFS_SVH
// ==========================================================
// bit positions, codes, bit counts, default address and reset values
`define BYTE_MSB        7
`define DIR_BIT         0
`define HS_CODE_MASK    8'hf8
`define HS_CODE_VALUE   8'h08
`define SETUP_SEL_HI    6
`define SETUP_SEL_LO    4
`define SETUP_CLK_BIT   3
`define SETUP_BIP_BIT   2
`define SETUP_RST_BIT   1
`define SETUP_RESET     8'h00
`define CONFIG_RESET    8'h01
`define CONFIG_SGL_BIT  0
`define BIT_COUNT_LAST  4'h7
`define BIT_COUNT_ACK   4'h8
`define BIT_COUNT_NINTH 4'h9
`define BIT_COUNT_ZERO  4'h0
`define SLAVE_ADDR_DEF  7'h35
`endif

// File: rtl/adc_i2c_pkg.sv
package adc_i2c_pkg;
	// ==========================================================
	// decoded setup fields
	typedef struct packed {
		logic [2:0] reference_select;
		logic       external_clock;
		logic       coding_polarity_select;
	} setup_fields_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_DATA,
		ST_DATA_ACK,
		ST_READ,
		ST_HS_NACK
	} slave_state_t;
endpackage

// File: rtl/adc_i2c_slave_setup_write.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_i2c_defs.svh"
module adc_i2c_slave_setup_write (
	input  wire logic                       ref_clk_in,
	input  wire logic                       rst_n_in,
	input  wire logic                       scl_in,
	input  wire logic                       sda_in,
	input  wire logic                       conversion_done_in,
	output var  logic                       sda_oe_n_out,
	output var  logic                       scl_oe_n_out,
	output var  logic                       high_speed_out,
	output var  logic                       read_request_out,
	output var  adc_i2c_pkg::setup_fields_t setup_out,
	output var  logic [7:0]                 config_out,
	output var  logic                       bipolar_active_out
);
	parameter logic [6:0] SLAVE_ADDR = `SLAVE_ADDR_DEF; // arbitrary default

	logic                      scl_s;
	logic                      sda_s;
	logic                      scl_q;
	logic                      sda_q;
	logic                      scl_rise;
	logic                      scl_fall;
	logic                      start_seen;
	logic                      stop_seen;
	adc_i2c_pkg::slave_state_t state;
	logic [3:0]                bit_count;
	logic [7:0]                shift;
	logic [7:0]                next_shift;
	logic                      hs_code;
	logic                      addr_match;
	logic                      read_dir;
	logic                      holding_scl;
	logic [7:0]                setup_reg;

	// ==========================================================
	// pin sampling and condition detect
	adc_i2c_sync u_scl_sync (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n_in),
		.async_in   (scl_in),
		.sync_out   (scl_s)
	);
	adc_i2c_sync u_sda_sync (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n_in),
		.async_in   (sda_in),
		.sync_out   (sda_s)
	);

	// delayed copies for edge finding
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	// edges and start stop conditions
	assign scl_rise   = scl_s & ~scl_q;
	assign scl_fall   = ~scl_s & scl_q;
	assign start_seen = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_seen  = scl_s & scl_q & ~sda_q & sda_s;
	assign next_shift = {shift[6:0], sda_s};
	assign hs_code    = (next_shift & `HS_CODE_MASK) == `HS_CODE_VALUE;
	assign addr_match = next_shift[7:1] == SLAVE_ADDR;

	// ==========================================================
	// byte engine
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			state     <= adc_i2c_pkg::ST_IDLE;
			bit_count <= `BIT_COUNT_ZERO;
			shift     <= 8'h00;
			read_dir  <= 1'b0;
		end else if (start_seen) begin
			state     <= adc_i2c_pkg::ST_ADDR;
			bit_count <= `BIT_COUNT_ZERO;
		end else if (stop_seen) begin
			state <= adc_i2c_pkg::ST_IDLE;
		end else begin
			case (state)
				adc_i2c_pkg::ST_ADDR, adc_i2c_pkg::ST_DATA: begin
					if (scl_rise) begin
						shift     <= next_shift;
						bit_count <= bit_count + 4'h1;
						if (bit_count == `BIT_COUNT_LAST) begin
							if (state == adc_i2c_pkg::ST_ADDR && hs_code) begin
								state <= adc_i2c_pkg::ST_HS_NACK;
							end else if (state == adc_i2c_pkg::ST_ADDR && addr_match) begin
								state    <= adc_i2c_pkg::ST_ADDR_ACK;
								read_dir <= next_shift[`DIR_BIT];
							end else if (state == adc_i2c_pkg::ST_DATA) begin
								state <= adc_i2c_pkg::ST_DATA_ACK;
							end else begin
								state <= adc_i2c_pkg::ST_IDLE;
							end
						end
					end
				end
				adc_i2c_pkg::ST_ADDR_ACK, adc_i2c_pkg::ST_DATA_ACK, adc_i2c_pkg::ST_HS_NACK: begin
					// count 8 covers the low phase before the ninth clock, 9 its high phase
					if (scl_rise) begin
						bit_count <= `BIT_COUNT_NINTH;
					end else if (scl_fall && bit_count == `BIT_COUNT_NINTH) begin
						bit_count <= `BIT_COUNT_ZERO;
						if (state == adc_i2c_pkg::ST_HS_NACK) begin
							state <= adc_i2c_pkg::ST_IDLE;
						end else if (state == adc_i2c_pkg::ST_ADDR_ACK && read_dir) begin
							state <= adc_i2c_pkg::ST_READ;
						end else begin
							state <= adc_i2c_pkg::ST_DATA;
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ack drive: low from fall after bit 8 until the ack clock falls
	// the hs code byte never reaches the drive branch, so sda stays released
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			sda_oe_n_out <= 1'b1;
		end else if (start_seen || stop_seen) begin
			sda_oe_n_out <= 1'b1;
		end else if (scl_fall && (state == adc_i2c_pkg::ST_ADDR_ACK || state == adc_i2c_pkg::ST_DATA_ACK)
				&& bit_count == `BIT_COUNT_ACK) begin
			sda_oe_n_out <= 1'b0;
		end else if (scl_fall && bit_count == `BIT_COUNT_NINTH) begin
			sda_oe_n_out <= 1'b1;
		end
	end

	// ==========================================================
	// bus speed mode
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			high_speed_out <= 1'b0;
		end else if (stop_seen) begin
			high_speed_out <= 1'b0;
		end else if (state == adc_i2c_pkg::ST_HS_NACK && scl_fall && bit_count == `BIT_COUNT_NINTH) begin
			high_speed_out <= 1'b1;
		end
	end

	// ==========================================================
	// setup and configuration registers
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			setup_reg  <= `SETUP_RESET;
			config_out <= `CONFIG_RESET;
		end else if (state == adc_i2c_pkg::ST_DATA_ACK && scl_rise) begin
			if (shift[`BYTE_MSB]) begin
				setup_reg <= shift;
				if (!shift[`SETUP_RST_BIT]) begin
					config_out <= `CONFIG_RESET;
				end
			end else begin
				config_out <= shift;
			end
		end
	end

	// decoded setup fields, bit 0 never used
	assign setup_out.reference_select       = setup_reg[`SETUP_SEL_HI:`SETUP_SEL_LO];
	assign setup_out.external_clock         = setup_reg[`SETUP_CLK_BIT];
	assign setup_out.coding_polarity_select = setup_reg[`SETUP_BIP_BIT];
	assign bipolar_active_out = setup_reg[`SETUP_BIP_BIT] & ~config_out[`CONFIG_SGL_BIT];

	// ==========================================================
	// internal clock conversion stretch
	// the hold request wins over a coincident done pulse
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			holding_scl <= 1'b0;
		end else if (state == adc_i2c_pkg::ST_ADDR_ACK && read_dir && scl_fall
				&& bit_count == `BIT_COUNT_NINTH && !setup_reg[`SETUP_CLK_BIT]) begin
			holding_scl <= 1'b1;
		end else if (stop_seen || start_seen || conversion_done_in) begin
			holding_scl <= 1'b0;
		end
	end
	assign scl_oe_n_out     = ~holding_scl;
	assign read_request_out = holding_scl;

	// ==========================================================
	// checks
	a_stop_fast_mode: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		stop_seen |=> !high_speed_out) else $error("hs not left on stop");
	a_rst_bit_config: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(state == adc_i2c_pkg::ST_DATA_ACK && scl_rise && shift[`BYTE_MSB] && !shift[`SETUP_RST_BIT])
		|=> config_out == `CONFIG_RESET) else $error("config not reset");
	a_setup_store: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(state == adc_i2c_pkg::ST_DATA_ACK && scl_rise && shift[`BYTE_MSB])
		|=> setup_reg == $past(shift)) else $error("setup not stored");
	a_config_store: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(state == adc_i2c_pkg::ST_DATA_ACK && scl_rise && !shift[`BYTE_MSB])
		|=> config_out == $past(shift) && $stable(setup_reg)) else $error("config not stored");
	a_hs_nack_free: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		state == adc_i2c_pkg::ST_HS_NACK |-> sda_oe_n_out)
		else $error("hs code acked");
	a_ack_low: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(state == adc_i2c_pkg::ST_ADDR_ACK && scl_rise) |-> !sda_oe_n_out)
		else $error("address not acked");
	a_data_ack_low: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(state == adc_i2c_pkg::ST_DATA_ACK && scl_rise) |-> !sda_oe_n_out)
		else $error("data not acked");
	a_single_unipolar: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		config_out[`CONFIG_SGL_BIT] |-> !bipolar_active_out) else $error("bipolar in single ended");
	a_idle_no_drive: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		state == adc_i2c_pkg::ST_IDLE |=> sda_oe_n_out) else $error("drive while idle");
	c_enter_hs: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) $rose(high_speed_out));
	c_setup_write: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) $changed(setup_reg));
	c_scl_hold: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) $rose(holding_scl));
endmodule
`default_nettype wire

// File: rtl/adc_i2c_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two-flop synchroniser for the bus pins
module adc_i2c_sync (
	input  wire logic ref_clk_in,
	input  wire logic rst_n_in,
	input  wire logic async_in,
	output var  logic sync_out
);
	logic meta;

	// meta is read only by the second stage
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			meta     <= 1'b1;
			sync_out <= 1'b1;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule
`default_nettype wire

// File: verif/adc_i2c_slave_setup_write_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// testbench
module adc_i2c_slave_setup_write_tb;
	localparam logic [6:0] DEV_ADDR = 7'h35; // arbitrary
	logic                       clk         = 1'b0;
	logic                       rst_n       = 1'b0;
	logic                       conv_done   = 1'b0;
	logic                       m_scl;
	logic                       m_sda;
	logic                       sda_oe_n;
	logic                       scl_oe_n;
	logic                       hs;
	logic                       rd_req;
	adc_i2c_pkg::setup_fields_t setup;
	logic [7:0]                 cfg;
	logic                       bip;
	logic                       ack;
	int                         fails       = 0;
	int                         comparisons = 0;
	int                         cycles      = 0;
	// pulled-up wires
	wire logic                  scl         = m_scl & scl_oe_n;
	wire logic                  sda         = m_sda & sda_oe_n;

	always #2.5 clk = ~clk;

	adc_i2c_slave_setup_write #(.SLAVE_ADDR(DEV_ADDR)) i_dut (
		.ref_clk_in(clk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda),
		.conversion_done_in(conv_done), .sda_oe_n_out(sda_oe_n), .scl_oe_n_out(scl_oe_n),
		.high_speed_out(hs), .read_request_out(rd_req), .setup_out(setup),
		.config_out(cfg), .bipolar_active_out(bip)
	);
	i2c_master_model i_master (.clk_in(clk), .sda_in(sda), .scl_out(m_scl), .sda_out(m_sda));

	// compare and count
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// start plus own address with direction bit
	task automatic addr(input logic rw);
		i_master.start();
		i_master.wr_byte({DEV_ADDR, rw}, ack);
		check("addr_ack", ack, 8'h00);
	endtask
	task automatic wr(input logic [7:0] d);
		i_master.wr_byte(d, ack);
		check("data_ack", ack, 8'h00);
	endtask
	// cut a hang short
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fails++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		i_master.tick(4);
		check("hs", hs, 8'h00);
		check("cfg", cfg, 8'h01);
		check("setup", {3'h0, setup}, 8'h00);
		// foreign address is ignored
		i_master.start();
		i_master.wr_byte({DEV_ADDR ^ 7'h01, 1'b0}, ack);
		check("foreign_ack", ack, 8'h01);
		i_master.wr_byte(8'hfe, ack);
		check("foreign_data", ack, 8'h01);
		i_master.stop();
		check("setup", {3'h0, setup}, 8'h00);
		// setup then configuration
		addr(1'b0);
		wr(8'hff);
		check("setup", {3'h0, setup}, 8'h1f);
		wr(8'h20);
		check("cfg", cfg, 8'h20);
		check("bip", bip, 8'h01);
		i_master.stop();
		// configuration then setup, ended by repeated start
		addr(1'b0);
		wr(8'h21);
		check("bip", bip, 8'h00);
		wr(8'hb7);
		check("setup", {3'h0, setup}, 8'h0d);
		check("cfg", cfg, 8'h21);
		addr(1'b0);
		wr(8'h85);
		check("cfg", cfg, 8'h01);
		check("setup", {3'h0, setup}, 8'h01);
		i_master.stop();
		// high-speed master code, repeated start, stop
		i_master.start();
		i_master.wr_byte(8'h0b, ack);
		check("hs_nack", ack, 8'h01);
		check("hs", hs, 8'h01);
		addr(1'b0);
		wr(8'h90);
		check("setup", {3'h0, setup}, 8'h04);
		check("hs", hs, 8'h01);
		i_master.stop();
		check("hs", hs, 8'h00);
		// read with internal clock holds scl
		addr(1'b1);
		i_master.tick(10);
		check("rd_req", rd_req, 8'h01);
		check("scl_hold", scl_oe_n, 8'h00);
		conv_done <= 1'b1;
		i_master.tick(1);
		conv_done <= 1'b0;
		i_master.tick(8);
		check("scl_free", scl_oe_n, 8'h01);
		check("rd_done", rd_req, 8'h00);
		i_master.stop();
		// external clock read never holds scl
		addr(1'b0);
		wr(8'h8a);
		check("setup", {3'h0, setup}, 8'h02);
		i_master.stop();
		addr(1'b1);
		i_master.tick(10);
		check("rd_ext", rd_req, 8'h00);
		check("scl_ext", scl_oe_n, 8'h01);
		i_master.stop();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// File: verif/i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bus master: open-drain scl and sda, scl stands high between frames
module i2c_master_model (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output var  logic scl_out,
	output var  logic sda_out
);
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// wait n clock edges
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// start or repeated start
	task automatic start();
		sda_out <= 1'b1;
		tick(6);
		scl_out <= 1'b1;
		tick(6);
		sda_out <= 1'b0;
		tick(6);
		scl_out <= 1'b0;
		tick(6);
	endtask
	task automatic stop();
		sda_out <= 1'b0;
		tick(6);
		scl_out <= 1'b1;
		tick(6);
		sda_out <= 1'b1;
		tick(6);
	endtask
	// one bit of 25 clocks, sda sampled mid high
	task automatic bit_io(input logic b, output logic s);
		sda_out <= b;
		tick(6);
		scl_out <= 1'b1;
		tick(6);
		s = sda_in;
		tick(6);
		scl_out <= 1'b0;
		tick(7);
	endtask
	// byte msb first, then release sda and return the ninth bit
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, ack);
	endtask
endmodule
`default_nettype wire
